// ===== call_return_pkg.sv
// Summary of operation
// - Address pointer upper six bits read zero
// - Direct call: decrement, push next, jump
// - Indirect call pushes next, jumps to pointer
// - Return pops pointer, then increments index
// - Return-and-skip pops, next instruction becomes no-op
// - Interrupt return pops and restores saved context
// - Interrupt saves only status word flags
// - Interrupt return restores context unconditionally
// - Unmask instruction sets global enable
// - Enable effective after following instruction completes
// - Accept after instruction, never after pointer change
// - Disabled source never alters program flow
// - Request held, accepted once enabled
// - Mask instruction clears global enable
// - No-op changes nothing, one machine cycle
package call_return_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int IP_W   = 10;
    localparam int AP_W   = 16;
    localparam int CTX_W  = 4;
    localparam int SI_W   = 3;
    localparam int II_W   = 2;
    localparam int ADDR_W = 5;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [15:0] OP_CALL_AR = 16'h3850;
    localparam logic [15:0] OP_BR_AR   = 16'h3840;
    localparam logic [15:0] OP_RET     = 16'h38E0;
    localparam logic [15:0] OP_RETURN_AND_SKIP   = 16'h39E0;
    localparam logic [15:0] OP_INTERRUPT_RETURN    = 16'h3CE0;
    localparam logic [15:0] OP_UNMASK  = 16'h38F0;
    localparam logic [15:0] OP_MASK    = 16'h39F0;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CONTROL  = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_ADDR_PTR = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_SRC_EN   = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_SRC_REQ  = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_POINTER  = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h1C;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int POS_SI        = 16;
    localparam int EVT_ACCEPT    = 0;
    localparam int EVT_STACK_ERR = 1;
    localparam int N_EVT         = 2;
    localparam logic [IP_W-1:0] RESET_IP = 10'h000;
    localparam logic [SI_W-1:0] RESET_SI = 3'h7;
    localparam logic [II_W-1:0] RESET_II = 2'h3;
    localparam logic [SI_W-1:0] SI_ONE   = 3'h1;
    localparam logic [II_W-1:0] II_ONE   = 2'h1;
    localparam logic [IP_W-1:0] IP_ONE   = 10'h001;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ===== call_return_interrupt_control.sv
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module call_return_interrupt_control
    import call_return_pkg::*;
#(
    parameter int N_SRC = 4,
    parameter logic [IP_W-1:0] VECTOR_BASE = 10'h001
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // AXI4-Lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Instruction issue, one pulse per machine cycle
    input  wire logic              instr_valid,
    input  wire logic [15:0]       instr_word,
    input  wire logic              direct_call,
    input  wire logic              branch_taken,
    input  wire logic [IP_W-1:0]   jump_target,
    // Interrupt sources
    input  wire logic [N_SRC-1:0]  source_event,
    // Sequencer outputs
    output logic [IP_W-1:0]        instruction_pointer,
    output logic                   skip_active,
    output logic                   global_irq_enable,
    output logic [CTX_W-1:0]       status_word_flags,
    output logic                   irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                          aw_got;
        logic [ADDR_W-1:0]             aw_addr;
        logic                          w_got;
        logic [31:0]                   w_data;
        logic [3:0]                    w_strb;
        logic                          awready;
        logic                          wready;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arready;
        logic                          rvalid;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
        logic [IP_W-1:0]               ip;
        logic                          skip;
        logic                          gie;
        logic [CTX_W-1:0]              live;
        logic [AP_W-1:0]               ap;
        logic [SI_W-1:0]               si;
        logic [II_W-1:0]               ii;
        logic [(1<<SI_W)-1:0][IP_W-1:0] ras;
        logic [(1<<II_W)-1:0][CTX_W-1:0] istk;
        logic [N_SRC-1:0]              src_en;
        logic [N_SRC-1:0]              src_req;
        logic [N_EVT-1:0]              irq_status;
        logic [N_EVT-1:0]              irq_mask;
        logic                          irq;
    } state_t;

    state_t s;
    state_t next_s;

    // ------------------------------------------------------------
    // Byte-lane merge for strobed writes
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0]      wv;
        logic             ipmod;
        logic             block;
        logic [N_SRC-1:0] ready_src;
        logic [N_EVT-1:0] evt;
        logic             found;
        logic [IP_W-1:0]  vec;
        logic [IP_W-1:0]  ret_addr;
        wv        = 32'h0000_0000;
        ipmod     = 1'b0;
        block     = 1'b0;
        ready_src = '0;
        evt       = '0;
        found     = 1'b0;
        vec       = VECTOR_BASE;
        ret_addr  = RESET_IP;
        next_s = s;

        // ------------------------------------------------------------
        // Write channel
        // ------------------------------------------------------------
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (awvalid && s.awready) begin
            next_s.aw_got  = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_got  = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (next_s.aw_got && next_s.w_got && !next_s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            unique case (next_s.aw_addr)
                OFF_CONTROL: begin
                    wv = merge({31'h0, s.gie}, next_s.w_data,
                               next_s.w_strb);
                    next_s.gie = wv[0];
                end
                OFF_ADDR_PTR: begin
                    wv = merge({16'h0, s.ap}, next_s.w_data,
                               next_s.w_strb);
                    next_s.ap = {6'h00, wv[IP_W-1:0]};
                end
                OFF_SRC_EN: begin
                    wv = merge(32'(s.src_en), next_s.w_data,
                               next_s.w_strb);
                    next_s.src_en = wv[N_SRC-1:0];
                end
                OFF_SRC_REQ: begin
                    wv = merge(32'h0, next_s.w_data, next_s.w_strb);
                    next_s.src_req = s.src_req & ~wv[N_SRC-1:0];
                end
                OFF_STATUS: begin
                    wv = merge(32'(s.live), next_s.w_data,
                               next_s.w_strb);
                    next_s.live = wv[CTX_W-1:0];
                end
                OFF_IRQ_STAT: begin
                    wv = merge(32'h0, next_s.w_data, next_s.w_strb);
                    next_s.irq_status = s.irq_status & ~wv[N_EVT-1:0];
                end
                OFF_IRQ_MASK: begin
                    wv = merge(32'(s.irq_mask), next_s.w_data,
                               next_s.w_strb);
                    next_s.irq_mask = wv[N_EVT-1:0];
                end
                OFF_POINTER: begin
                    next_s.bresp = RESP_OKAY;
                end
                default: begin
                    next_s.bresp = RESP_DECERR;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Read channel
        // ------------------------------------------------------------
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            unique case (araddr)
                OFF_CONTROL:  next_s.rdata = {31'h0, s.gie};
                OFF_ADDR_PTR: next_s.rdata = {22'h0, s.ap[IP_W-1:0]};
                OFF_SRC_EN:   next_s.rdata = 32'(s.src_en);
                OFF_SRC_REQ:  next_s.rdata = 32'(s.src_req);
                OFF_STATUS:   next_s.rdata = 32'(s.live);
                OFF_POINTER: begin
                    next_s.rdata = 32'(s.ip);
                    next_s.rdata[POS_SI +: SI_W] = s.si;
                end
                OFF_IRQ_STAT: next_s.rdata = 32'(s.irq_status);
                OFF_IRQ_MASK: next_s.rdata = 32'(s.irq_mask);
                default: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = RESP_DECERR;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Instruction execution
        // ------------------------------------------------------------
        if (instr_valid) begin
            next_s.ip = s.ip + IP_ONE;
            if (s.skip) begin
                next_s.skip = 1'b0;
            end else if (direct_call || instr_word == OP_CALL_AR) begin
                ipmod = 1'b1;
                // Wrap is flagged, not blocked
                if (s.si == '0) begin
                    evt[EVT_STACK_ERR] = 1'b1;
                end
                next_s.si = s.si - SI_ONE;
                next_s.ras[next_s.si] = s.ip + IP_ONE;
                next_s.ip = direct_call ? jump_target : s.ap[IP_W-1:0];
            end else if (instr_word == OP_RET || instr_word == OP_RETURN_AND_SKIP ||
                         instr_word == OP_INTERRUPT_RETURN) begin
                ipmod = 1'b1;
                next_s.ip = s.ras[s.si];
                if (s.si == RESET_SI) begin
                    evt[EVT_STACK_ERR] = 1'b1;
                end
                next_s.si = s.si + SI_ONE;
                next_s.skip = (instr_word == OP_RETURN_AND_SKIP);
                if (instr_word == OP_INTERRUPT_RETURN) begin
                    next_s.live = s.istk[s.ii];
                    next_s.ii   = s.ii + II_ONE;
                end
            end else if (instr_word == OP_BR_AR || branch_taken) begin
                ipmod = 1'b1;
                next_s.ip = branch_taken ? jump_target : s.ap[IP_W-1:0];
            end else if (instr_word == OP_UNMASK) begin
                next_s.gie = 1'b1;
            end else if (instr_word == OP_MASK) begin
                next_s.gie = 1'b0;
                block = 1'b1;
            end

            // ------------------------------------------------------------
            // Interrupt acceptance
            // ------------------------------------------------------------
            // only enabled pending sources
            ready_src = s.src_req & s.src_en;
            if (s.gie && !ipmod && !block && |ready_src) begin
                for (int i = N_SRC - 1; i >= 0; i--) begin
                    if (ready_src[i]) begin
                        found = 1'b1;
                        vec = VECTOR_BASE + IP_W'(i);
                    end
                end
            end
            if (found) begin
                ret_addr = next_s.ip;
                if (s.si == '0) begin
                    evt[EVT_STACK_ERR] = 1'b1;
                end
                next_s.si = s.si - SI_ONE;
                next_s.ras[next_s.si] = ret_addr;
                next_s.ii = s.ii - II_ONE;
                next_s.istk[next_s.ii] = next_s.live;
                next_s.ip = vec;
                evt[EVT_ACCEPT] = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // Request flags: set wins over clears
        // ------------------------------------------------------------
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (found && vec == VECTOR_BASE + IP_W'(i)) begin
                next_s.src_req[i] = 1'b0;
            end
            if (source_event[i]) begin
                next_s.src_req[i] = 1'b1;
            end
        end
        next_s.irq_status = next_s.irq_status | evt;

        // Level output follows unmasked status
        next_s.irq     = |(next_s.irq_status & next_s.irq_mask);
        // Readies drop while a response waits
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;

        // ------------------------------------------------------------
        // Synchronous reset overrides all
        // ------------------------------------------------------------
        if (!aresetn) begin
            next_s    = '0;
            next_s.ip = RESET_IP;
            next_s.si = RESET_SI;
            next_s.ii = RESET_II;
        end
    end

    always_ff @(posedge aclk) begin
        s <= next_s;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign awready             = s.awready;
    assign wready              = s.wready;
    assign bvalid              = s.bvalid;
    assign bresp               = s.bresp;
    assign arready             = s.arready;
    assign rvalid              = s.rvalid;
    assign rdata               = s.rdata;
    assign rresp               = s.rresp;
    assign instruction_pointer = s.ip;
    assign skip_active         = s.skip;
    assign global_irq_enable   = s.gie;
    assign status_word_flags   = s.live;
    assign irq                 = s.irq;

endmodule

// ===== call_return_checker_assertions.sv
`timescale 1ns/1ps
module call_return_checker
    import call_return_pkg::*;
(
    // Clock and reset
    input wire logic            aclk,
    input wire logic            aresetn,
    // Instruction issue
    input wire logic            instr_valid,
    input wire logic [15:0]     instr_word,
    input wire logic            direct_call,
    input wire logic            branch_taken,
    input wire logic [IP_W-1:0] jump_target,
    // Sequencer state
    input wire logic [IP_W-1:0] instruction_pointer,
    input wire logic            skip_active,
    input wire logic            global_irq_enable,
    input wire logic            irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic live;
    assign live = instr_valid && !skip_active;

    property p_unmask;
        live && instr_word == OP_UNMASK |=> global_irq_enable;
    endproperty
    a_unmask: assert property (p_unmask)
        else $error("unmask left enable low");
    property p_mask;
        live && instr_word == OP_MASK |=> !global_irq_enable
            && instruction_pointer == $past(instruction_pointer) + IP_ONE;
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask did not block");
    property p_unmask_hold;
        live && instr_word == OP_UNMASK
            |=> instruction_pointer == $past(instruction_pointer) + IP_ONE;
    endproperty
    a_unmask_hold: assert property (p_unmask_hold)
        else $error("accept right after unmask");
    property p_call;
        live && direct_call |=> instruction_pointer == $past(jump_target);
    endproperty
    a_call: assert property (p_call)
        else $error("direct call target wrong");
    property p_return_and_skip;
        live && instr_word == OP_RETURN_AND_SKIP |=> skip_active;
    endproperty
    a_return_and_skip: assert property (p_return_and_skip)
        else $error("return and skip set no skip");
    property p_ret;
        live && instr_word == OP_RET |=> !skip_active;
    endproperty
    a_ret: assert property (p_ret)
        else $error("plain return set skip");
    property p_nop;
        instr_valid && skip_active |=> !skip_active;
    endproperty
    a_nop: assert property (p_nop)
        else $error("skip lasted beyond one cycle");
    property p_branch;
        live && branch_taken && !direct_call && instr_word != OP_CALL_AR
            && instr_word[7:4] != 4'hE
            |=> instruction_pointer == $past(jump_target);
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch target lost to accept");
    property p_idle;
        !instr_valid |=> $stable(instruction_pointer);
    endproperty
    a_idle: assert property (p_idle)
        else $error("pointer moved without instruction");

    c_return_and_skip: cover property (live && instr_word == OP_RETURN_AND_SKIP);
    c_call: cover property (live && direct_call);
    c_irq: cover property ($rose(irq));
    c_branch: cover property (live && branch_taken);
endmodule

bind call_return_interrupt_control call_return_checker u_chk (
    .aclk, .aresetn, .instr_valid, .instr_word, .direct_call,
    .branch_taken, .jump_target, .instruction_pointer, .skip_active,
    .global_irq_enable, .irq);

// ===== test_call_return_interrupt_control.sv
`timescale 1ns/1ps
module test_call_return_interrupt_control
    import call_return_pkg::*;
;
    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid;
    logic              rready, instr_valid, direct_call, branch_taken;
    logic              awready, wready, bvalid, arready, rvalid;
    logic              skip_active, global_irq_enable, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, rv;
    logic [3:0]        wstrb, source_event;
    logic [2:0]        awprot, arprot;
    logic [1:0]        bresp, rresp, br, rr;
    logic [15:0]       instr_word;
    logic [IP_W-1:0]   jump_target, instruction_pointer;
    logic [CTX_W-1:0]  status_word_flags;
    int                num_errors, checked;
    localparam logic [IP_W-1:0] VECTOR_BASE_TB = 10'h001;

    call_return_interrupt_control uut (
        .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .instr_valid, .instr_word, .direct_call, .branch_taken,
        .jump_target, .source_event, .instruction_pointer, .skip_active,
        .global_irq_enable, .status_word_flags, .irq);

    always #50 aclk = !aclk;

    // ----------------------------------------------------------------
    // Bus and issue tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        br = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        chk(rv, e, "read data");
    endtask

    task automatic ex(input logic [15:0] w, input logic dc,
                      input logic [IP_W-1:0] t);
        @(posedge aclk);
        instr_valid <= 1'b1;
        instr_word <= w;
        direct_call <= dc;
        jump_target <= t;
        @(posedge aclk);
        instr_valid <= 1'b0;
        direct_call <= 1'b0;
        branch_taken <= 1'b0;
        @(negedge aclk);
    endtask

    task automatic ev(input logic [3:0] m);
        @(posedge aclk);
        source_event <= m;
        @(posedge aclk);
        source_event <= 4'h0;
    endtask

    task automatic cip(input logic [IP_W-1:0] e);
        chk({22'h0, instruction_pointer}, {22'h0, e}, "pointer");
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rdc(OFF_POINTER, 32'h0007_0000);
        chk({28'h0, status_word_flags}, 32'h0, "flags");
        wr(OFF_ADDR_PTR, 32'hFFFF_FFFF);
        rdc(OFF_ADDR_PTR, 32'h0000_03FF);
        wr(OFF_ADDR_PTR, 32'h0000_0020);
        $display("test reset and pointer done");
    endtask

    task automatic t_calls;
        ex(OP_CALL_AR, 1'b0, 10'h000);
        rdc(OFF_POINTER, 32'h0006_0020);
        ex(OP_RET, 1'b0, 10'h000);
        rdc(OFF_POINTER, 32'h0007_0001);
        ex(16'h0000, 1'b1, 10'h040);
        cip(10'h040);
        ex(OP_RETURN_AND_SKIP, 1'b0, 10'h000);
        cip(10'h002);
        chk({31'h0, skip_active}, 32'h1, "skip");
        ex(OP_UNMASK, 1'b0, 10'h000);
        cip(10'h003);
        chk({31'h0, global_irq_enable}, 32'h0, "enable");
        $display("test calls and returns done");
    endtask

    task automatic t_irq;
        wr(OFF_SRC_EN, 32'h0);
        wr(OFF_STATUS, 32'h5);
        wr(OFF_IRQ_MASK, 32'h1);
        ev(4'h2);
        rdc(OFF_SRC_REQ, 32'h2);
        ex(OP_UNMASK, 1'b0, 10'h000);
        chk({31'h0, global_irq_enable}, 32'h1, "enable");
        ex(16'h0000, 1'b0, 10'h000);
        cip(10'h005);
        wr(OFF_SRC_EN, 32'h2);
        ex(16'h0000, 1'b0, 10'h000);
        cip(VECTOR_BASE_TB + IP_ONE);
        rdc(OFF_POINTER, 32'h0006_0002);
        rdc(OFF_SRC_REQ, 32'h0);
        rdc(OFF_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h1, "irq high");
        wr(OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq low");
        wr(OFF_STATUS, 32'hA);
        ex(OP_INTERRUPT_RETURN, 1'b0, 10'h000);
        cip(10'h006);
        chk({28'h0, status_word_flags}, 32'h5, "flags");
        $display("test interrupt accept done");
    endtask

    task automatic t_mask;
        ex(OP_MASK, 1'b0, 10'h000);
        chk({31'h0, global_irq_enable}, 32'h0, "enable");
        ev(4'h2);
        ex(16'h0000, 1'b0, 10'h000);
        cip(10'h008);
        ex(OP_UNMASK, 1'b0, 10'h000);
        cip(10'h009);
        ex(16'h0000, 1'b0, 10'h000);
        cip(VECTOR_BASE_TB + IP_ONE);
        ex(OP_INTERRUPT_RETURN, 1'b0, 10'h000);
        cip(10'h00A);
        $display("test mask and delayed enable done");
    endtask

    task automatic t_branch;
        ev(4'h2);
        ex(OP_BR_AR, 1'b0, 10'h000);
        cip(10'h020);
        ex(16'h0000, 1'b0, 10'h000);
        cip(VECTOR_BASE_TB + IP_ONE);
        ex(OP_INTERRUPT_RETURN, 1'b0, 10'h000);
        cip(10'h021);
        @(posedge aclk);
        branch_taken <= 1'b1;
        ex(16'h0000, 1'b0, 10'h030);
        cip(10'h030);
        wr(OFF_STATUS, 32'h3);
        ex(16'h0000, 1'b1, 10'h100);
        ex(OP_INTERRUPT_RETURN, 1'b0, 10'h000);
        cip(10'h031);
        chk({28'h0, status_word_flags}, 32'h0, "flags");
        $display("test branch and subroutine return done");
    endtask

    task automatic t_bus;
        wr(OFF_CONTROL, 32'h0);
        chk({30'h0, br}, {30'h0, RESP_OKAY}, "write resp");
        rdc(OFF_CONTROL, 32'h0);
        chk({30'h0, rr}, {30'h0, RESP_OKAY}, "read resp");
        chk({31'h0, global_irq_enable}, 32'h0, "enable");
        wr(5'h02, 32'h1);
        chk({30'h0, br}, {30'h0, RESP_DECERR}, "write resp");
        rdc(5'h02, 32'h0);
        chk({30'h0, rr}, {30'h0, RESP_DECERR}, "read resp");
        ex(OP_RET, 1'b0, 10'h000);
        rdc(OFF_IRQ_STAT, 32'h3);
        rdc(OFF_POINTER, 32'h0);
        $display("test bus responses and stack wrap done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {instr_valid, direct_call, branch_taken} = 3'h0;
        {awaddr, araddr, wdata, instr_word} = '0;
        {awprot, arprot, jump_target, source_event} = '0;
        wstrb = 4'hF;
        num_errors = 0;
        checked = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_calls();
        t_irq();
        t_mask();
        t_branch();
        t_bus();
        report_and_stop();
    end
endmodule
